// ===== core/ccc_clock_controller.sv
// chip clock controller: sources, muxes, gates, divider, power-down sequencing
// Functional notes
// - power-down needs enable bit plus wait-for-interrupt
// - stay down until wake interrupt, then resume
// - power-down stops crystal and high RC
// - three sources: crystal, high RC, low RC
// - system clock chosen by select bits 2:0
// - tick timer counts core or external tick
// - external tick from four sources, bits 5:3
// - per-peripheral engine clock source choices fixed
// - low RC runs throughout power-down
// - low crystal kept only with keepalive and 10
// - watchdog, timers live down only on low RC
// - everything else stopped in power-down
// - per-clock gate, source select, 4-bit divider
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module ccc_clock_controller (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        wfiExec,
    input  wire logic        wakeIrq,
    input  wire logic        xtalOsc,
    input  wire logic        hircOsc,
    input  wire logic        lircOsc,
    output logic             xtalEnable,
    output logic             hircEnable,
    output logic             lircEnable,
    output logic             powerDown,
    output logic             sysClkTick,
    output logic             extTickClk,
    output logic             systickCountTick,
    output logic [8:0]       periTick,
    output logic             divTick
);
    localparam int NP = ccc_pkg::NUM_PERI;

    // software-visible registers
    logic [4:0]      pwrCtrl_q, pwrCtrl_d;
    logic [5:0]      clkSel_q, clkSel_d;
    logic [17:0]     periSel_q, periSel_d;
    logic [8:0]      clkEn_q, clkEn_d;
    logic [6:0]      divider_q, divider_d;
    logic [2:0]      tickCsr_q, tickCsr_d;
    logic [31:0]     rdData_q, rdData_d;
    logic            ack_q, ack_d;

    // power state and oscillator controls
    ccc_pkg::ccc_pm_state_t state_q, state_d;
    logic            xtalEn_q, xtalEn_d;
    logic            hircEn_q, hircEn_d;
    logic            lircEn_q, lircEn_d;
    logic            entryCond;
    logic            downNow;

    // oscillator synchronisers and edge detect
    logic [2:0]      oscMeta_q, oscSync_q, oscLast_q;
    logic [2:0]      oscRise;
    logic            xtalLive, hircLive, lircLive;
    logic [3:0]      srcTick;
    logic [3:0]      sysSrc;
    logic [1:0]      sysIdx;
    logic [1:0]      tickIdx;
    logic            stCount_q, stCount_d;

    // bus write helpers
    logic            access;
    logic            wrStrobe;
    logic [31:0]     laneMask;
    logic [31:0]     wrWord;
    logic [31:0]     statusWord;

    // oscillator pins come from other clocks: two flops before any use
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            oscMeta_q <= 3'h0;
            oscSync_q <= 3'h0;
            oscLast_q <= 3'h0;
        end else begin
            oscMeta_q <= {lircOsc, hircOsc, xtalOsc};
            oscSync_q <= oscMeta_q;
            oscLast_q <= oscSync_q;
        end
    end

    // source ticks only count while their oscillator is enabled
    assign oscRise  = oscSync_q & ~oscLast_q;
    assign xtalLive = oscRise[0] & xtalEn_q;
    assign hircLive = oscRise[1] & hircEn_q;
    assign lircLive = oscRise[2] & lircEn_q;
    // peripheral bus clock follows the system clock
    assign srcTick  = {sysClkTick, lircLive, hircLive, xtalLive};

    // classic single-cycle slave: ack one cycle after strobe, then drop
    assign access   = wb_cyc_i & wb_stb_i & ~ack_q;
    // a write lands on the edge where the master sees ack, while it still holds the request
    assign wrStrobe = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    assign laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wrWord   = wb_dat_i & laneMask;
    assign statusWord = {28'h0, hircEn_q, xtalEn_q, lircEn_q, powerDown};

    // register file next values; byte lanes preserve untouched bits
    always_comb begin
        pwrCtrl_d = pwrCtrl_q;
        clkSel_d  = clkSel_q;
        periSel_d = periSel_q;
        clkEn_d   = clkEn_q;
        divider_d = divider_q;
        tickCsr_d = tickCsr_q;
        rdData_d  = rdData_q;
        ack_d     = access;
        if (wrStrobe) begin
            case (wb_adr_i)
                ccc_pkg::OFF_PWR_CTRL:
                    pwrCtrl_d = (pwrCtrl_q & ~laneMask[4:0]) | wrWord[4:0];
                ccc_pkg::OFF_CLK_SELECT:
                    clkSel_d = (clkSel_q & ~laneMask[5:0]) | wrWord[5:0];
                ccc_pkg::OFF_PERI_SEL:
                    periSel_d = (periSel_q & ~laneMask[17:0]) | wrWord[17:0];
                ccc_pkg::OFF_CLK_ENABLE:
                    clkEn_d = (clkEn_q & ~laneMask[8:0]) | wrWord[8:0];
                ccc_pkg::OFF_DIVIDER:
                    divider_d = (divider_q & ~laneMask[6:0]) | wrWord[6:0];
                ccc_pkg::OFF_TICK_CSR:
                    tickCsr_d = (tickCsr_q & ~laneMask[2:0]) | wrWord[2:0];
                default: ;
            endcase
        end
        if (access && !wb_we_i) begin
            case (wb_adr_i)
                ccc_pkg::OFF_PWR_CTRL:   rdData_d = {27'h0, pwrCtrl_q};
                ccc_pkg::OFF_CLK_SELECT: rdData_d = {26'h0, clkSel_q};
                ccc_pkg::OFF_PERI_SEL:   rdData_d = {14'h0, periSel_q};
                ccc_pkg::OFF_CLK_ENABLE: rdData_d = {23'h0, clkEn_q};
                ccc_pkg::OFF_DIVIDER:    rdData_d = {25'h0, divider_q};
                ccc_pkg::OFF_TICK_CSR:   rdData_d = {29'h0, tickCsr_q};
                ccc_pkg::OFF_STATUS:     rdData_d = statusWord;
                default:                 rdData_d = 32'h0; // unmapped reads zero
            endcase
        end
    end

    // register file
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pwrCtrl_q <= ccc_pkg::PWR_CTRL_RST;
            clkSel_q  <= ccc_pkg::CLK_SEL_RST;
            periSel_q <= ccc_pkg::PERI_SEL_RST;
            clkEn_q   <= ccc_pkg::CLK_EN_RST;
            divider_q <= ccc_pkg::DIVIDER_RST;
            tickCsr_q <= ccc_pkg::TICK_CSR_RST;
            rdData_q  <= 32'h0;
            ack_q     <= 1'b0;
        end else begin
            pwrCtrl_q <= pwrCtrl_d;
            clkSel_q  <= clkSel_d;
            periSel_q <= periSel_d;
            clkEn_q   <= clkEn_d;
            divider_q <= divider_d;
            tickCsr_q <= tickCsr_d;
            rdData_q  <= rdData_d;
            ack_q     <= ack_d;
        end
    end

    // wfi alone or the enable bit alone never powers down
    assign entryCond = pwrCtrl_q[ccc_pkg::POWER_DOWN_ENABLE_BIT] & wfiExec;

    // power state machine; oscillator enables follow the next state
    // so that the enables and powerDown change on the same edge
    always_comb begin
        state_d = state_q;
        case (state_q)
            ccc_pkg::PM_RUN:  if (entryCond) state_d = ccc_pkg::PM_DOWN;
            ccc_pkg::PM_DOWN: if (wakeIrq) state_d = ccc_pkg::PM_RUN;
            default:          state_d = ccc_pkg::PM_RUN;
        endcase
        lircEn_d = 1'b1;
        if (state_d == ccc_pkg::PM_DOWN) begin
            hircEn_d = 1'b0;
            xtalEn_d = pwrCtrl_q[ccc_pkg::KEEPALIVE_BIT] &&
                       (pwrCtrl_q[ccc_pkg::XTAL_EN_LSB +: 2] == ccc_pkg::XTAL_EN_LOW);
        end else begin
            hircEn_d = pwrCtrl_q[ccc_pkg::HIGH_FREQ_RC_OSC_EN_BIT];
            xtalEn_d = pwrCtrl_q[ccc_pkg::XTAL_EN_LSB +: 2] != ccc_pkg::XTAL_EN_OFF;
        end
    end

    // power state registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_q  <= ccc_pkg::PM_RUN;
            xtalEn_q <= 1'b0;
            hircEn_q <= 1'b1;
            lircEn_q <= 1'b1;
        end else begin
            state_q  <= state_d;
            xtalEn_q <= xtalEn_d;
            hircEn_q <= hircEn_d;
            lircEn_q <= lircEn_d;
        end
    end

    assign downNow = (state_q == ccc_pkg::PM_DOWN);

    // system clock select: unknown codes fall back to the high RC
    always_comb begin
        case (clkSel_q[2:0])
            ccc_pkg::SYS_SEL_XTAL: sysIdx = ccc_pkg::SRC_XTAL;
            ccc_pkg::SYS_SEL_LOW_FREQ_RC_OSC: sysIdx = ccc_pkg::SRC_LOW_FREQ_RC_OSC;
            ccc_pkg::SYS_SEL_HIGH_FREQ_RC_OSC: sysIdx = ccc_pkg::SRC_HIGH_FREQ_RC_OSC;
            default:               sysIdx = ccc_pkg::SRC_HIGH_FREQ_RC_OSC;
        endcase
    end
    // the system clock may not feed itself
    assign sysSrc  = {1'b0, srcTick[2:0]};
    // external tick: four sources, larger codes pick the bus clock
    assign tickIdx = (clkSel_q[5:3] > ccc_pkg::TICK_SEL_MAX) ? ccc_pkg::SRC_PCLK
                                                             : clkSel_q[4:3];

    ccc_glitchfree_mux uSysMux (
        .mclk    (mclk),
        .reset_n (reset_n),
        .srcTick (sysSrc),
        .sel     (sysIdx),
        .allow   (~downNow),
        .tickOut (sysClkTick)
    );

    ccc_glitchfree_mux uTickMux (
        .mclk    (mclk),
        .reset_n (reset_n),
        .srcTick (srcTick),
        .sel     (tickIdx),
        .allow   (~downNow),
        .tickOut (extTickClk)
    );

    // tick timer count source: bit set counts the core clock
    assign stCount_d = tickCsr_q[ccc_pkg::TICK_SRC_BIT] ? sysClkTick : extTickClk;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            stCount_q <= 1'b0;
        end else begin
            stCount_q <= stCount_d;
        end
    end
    assign systickCountTick = stCount_q;

    // per-peripheral gate and source; illegal sources simply give no clock
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : gPeri
            logic [1:0] pSel;
            logic       pAllow;
            assign pSel   = periSel_q[2*gi +: 2];
            assign pAllow = clkEn_q[gi] & ccc_pkg::PERI_ALLOW[gi][pSel] &
                            (~downNow | (ccc_pkg::PERI_KEEP[gi] &
                                         (pSel == ccc_pkg::SRC_LOW_FREQ_RC_OSC)));
            ccc_glitchfree_mux uPeriMux (
                .mclk    (mclk),
                .reset_n (reset_n),
                .srcTick (srcTick),
                .sel     (pSel),
                .allow   (pAllow),
                .tickOut (periTick[gi])
            );
        end
    endgenerate

    // frequency divider output with its own source select
    logic divSrcTick;
    ccc_glitchfree_mux uDivMux (
        .mclk    (mclk),
        .reset_n (reset_n),
        .srcTick (srcTick),
        .sel     (divider_q[ccc_pkg::DIV_SRC_LSB +: 2]),
        .allow   (~downNow),
        .tickOut (divSrcTick)
    );
    ccc_tick_divider uDiv (
        .mclk    (mclk),
        .reset_n (reset_n),
        .tickIn  (divSrcTick),
        .ratio   (divider_q[3:0]),
        .enable  (divider_q[ccc_pkg::DIV_EN_BIT]),
        .tickOut (divTick)
    );

    assign wb_dat_o   = rdData_q;
    assign wb_ack_o   = ack_q;
    assign powerDown  = downNow;
    assign xtalEnable = xtalEn_q;
    assign hircEnable = hircEn_q;
    assign lircEnable = lircEn_q;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_entry_needs_both: assert property ($rose(powerDown) |-> $past(entryCond))
        else $error("power-down entered without enable and wfi");
    chk_no_entry_alone: assert property (
        (!powerDown && wfiExec && !pwrCtrl_q[0]) |=> !powerDown)
        else $error("wfi alone caused power-down");
    chk_wake_exit: assert property ((powerDown && wakeIrq) |=> !powerDown)
        else $error("wake interrupt did not end power-down");
    chk_stay_down: assert property ((powerDown && !wakeIrq) |=> powerDown)
        else $error("left power-down without wake");
    chk_high_freq_rc_osc_off_down: assert property (powerDown |-> !hircEnable)
        else $error("high rc running in power-down");
    chk_low_freq_rc_osc_alive: assert property (powerDown |-> lircEnable)
        else $error("low rc stopped in power-down");
    chk_xtal_keep: assert property (
        (powerDown && xtalEnable) |-> (pwrCtrl_q[1] && pwrCtrl_q[3:2] == 2'h2))
        else $error("crystal running in power-down without keepalive");
    chk_sys_gated: assert property ((powerDown && $past(powerDown)) |-> !sysClkTick)
        else $error("system clock ticked in power-down");
    chk_peri_gated: assert property (
        (powerDown && $past(powerDown)) |-> ((periTick & ~ccc_pkg::PERI_KEEP) == 9'h000))
        else $error("non keep-alive peripheral clock in power-down");
    chk_systick_src: assert property (
        ($past(tickCsr_q[2]) && $past(sysClkTick)) |-> systickCountTick)
        else $error("tick timer missed core clock tick");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for two cycles");
endmodule // ccc_clock_controller
`default_nettype wire

// ===== core/ccc_glitchfree_mux.sv
// clock-enable multiplexer that never emits a partial period on switching
`timescale 1ns/100ps
`default_nettype none
module ccc_glitchfree_mux (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic [3:0] srcTick,
    input  wire logic [1:0] sel,
    input  wire logic       allow,
    output logic            tickOut
);
    logic [1:0] curSel_q, curSel_d;
    logic       blank_q, blank_d;
    logic       tick_q, tick_d;

    // on a select change go silent until the new source marks a period start
    always_comb begin
        curSel_d = curSel_q;
        blank_d  = blank_q;
        tick_d   = allow & ~blank_q & srcTick[curSel_q];
        if (sel != curSel_q) begin
            curSel_d = sel;
            blank_d  = 1'b1;
            tick_d   = 1'b0;
        end else if (blank_q && srcTick[curSel_q]) begin
            blank_d = 1'b0;
        end
    end

    // state registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            curSel_q <= 2'h0;
            blank_q  <= 1'b1;
            tick_q   <= 1'b0;
        end else begin
            curSel_q <= curSel_d;
            blank_q  <= blank_d;
            tick_q   <= tick_d;
        end
    end

    assign tickOut = tick_q;
endmodule // ccc_glitchfree_mux
`default_nettype wire

// ===== core/ccc_pkg.sv
// constants and encodings shared by the clock controller files
package ccc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_PWR_CTRL   = 8'h00;
    localparam logic [7:0] OFF_CLK_SELECT = 8'h04;
    localparam logic [7:0] OFF_PERI_SEL   = 8'h08;
    localparam logic [7:0] OFF_CLK_ENABLE = 8'h0C;
    localparam logic [7:0] OFF_DIVIDER    = 8'h10;
    localparam logic [7:0] OFF_TICK_CSR   = 8'h14;
    localparam logic [7:0] OFF_STATUS     = 8'h18;

    // power control, tick control and divider field positions
    localparam int POWER_DOWN_ENABLE_BIT  = 0;
    localparam int KEEPALIVE_BIT    = 1;
    localparam int XTAL_EN_LSB      = 2;
    localparam int HIGH_FREQ_RC_OSC_EN_BIT      = 4;
    localparam int TICK_SRC_BIT     = 2;
    localparam int DIV_EN_BIT       = 4;
    localparam int DIV_SRC_LSB      = 5;

    // values after reset
    localparam logic [4:0]  PWR_CTRL_RST  = 5'h10;
    localparam logic [5:0]  CLK_SEL_RST   = 6'h07;
    localparam logic [17:0] PERI_SEL_RST  = 18'h3FFFF;
    localparam logic [8:0]  CLK_EN_RST    = 9'h000;
    localparam logic [6:0]  DIVIDER_RST   = 7'h00;
    localparam logic [2:0]  TICK_CSR_RST  = 3'h4;

    // source indices into a four-entry tick vector
    localparam logic [1:0] SRC_XTAL = 2'h0;
    localparam logic [1:0] SRC_HIGH_FREQ_RC_OSC = 2'h1;
    localparam logic [1:0] SRC_LOW_FREQ_RC_OSC = 2'h2;
    localparam logic [1:0] SRC_PCLK = 2'h3;

    // system clock select codes and the highest external tick select code
    localparam logic [2:0] SYS_SEL_XTAL = 3'h0;
    localparam logic [2:0] SYS_SEL_LOW_FREQ_RC_OSC = 3'h3;
    localparam logic [2:0] SYS_SEL_HIGH_FREQ_RC_OSC = 3'h7;
    localparam logic [2:0] TICK_SEL_MAX = 3'h3;

    // crystal enable field values: the one that keeps the low crystal alive, and off
    localparam logic [1:0] XTAL_EN_LOW  = 2'h2;
    localparam logic [1:0] XTAL_EN_OFF  = 2'h0;

    // peripheral order: wdt tmr0 tmr1 i2c spi uart pwm adc acmp
    localparam int NUM_PERI = 9;
    localparam logic [NUM_PERI-1:0][3:0] PERI_ALLOW = 36'h8B8388FFD;
    localparam logic [NUM_PERI-1:0]      PERI_KEEP  = 9'h007;

    typedef enum logic [1:0] {
        PM_RUN  = 2'b00,
        PM_DOWN = 2'b01
    } ccc_pm_state_t;
endpackage

// ===== core/ccc_tick_divider.sv
// 4-bit divider on a tick stream: one output per ratio+1 input ticks
`timescale 1ns/100ps
`default_nettype none
module ccc_tick_divider (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       tickIn,
    input  wire logic [3:0] ratio,
    input  wire logic       enable,
    output logic            tickOut
);
    logic [3:0] count_q, count_d;
    logic       tick_q, tick_d;

    // counter restarts when disabled so the first period is always whole
    always_comb begin
        count_d = count_q;
        tick_d  = 1'b0;
        if (!enable) begin
            count_d = 4'h0;
        end else if (tickIn) begin
            if (count_q >= ratio) begin
                count_d = 4'h0;
                tick_d  = 1'b1;
            end else begin
                count_d = count_q + 4'h1;
            end
        end
    end

    // registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            count_q <= 4'h0;
            tick_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            tick_q  <= tick_d;
        end
    end

    assign tickOut = tick_q;
endmodule // ccc_tick_divider
`default_nettype wire

// ===== sim/ccc_clock_controller_tb_top.sv
// self-checking bench for the clock controller
`timescale 1ns/100ps
`default_nettype none
module ccc_clock_controller_tb_top;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0]  sel = 4'hF;
    logic [31:0] datO;
    logic        ack;
    logic        wfi = 1'b0;
    logic        wake = 1'b0;
    logic        xO, hO, lO, xE, hE, lE, pd, sysT, extT, cntT, divT, xP, hP, lP;
    logic [8:0]  periT;
    logic [31:0] r;
    int          cnt[16];
    int          d[16];
    int          err_total = 0;
    int          n_compared = 0;
    // allowed sources per peripheral, four bits each: pclk low_freq_rc_osc high_freq_rc_osc xtal
    localparam logic [35:0] OK_TAB = {4'b1000, 4'b1011, 4'b1000, 4'b0011, 4'b1000,
                                      4'b1000, 4'b1111, 4'b1111, 4'b1101};
    localparam int SRC_IDX[4] = '{13, 14, 12, 9};

    ccc_clock_controller i_ccc_clock_controller (.mclk(mclk), .reset_n(reset_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(sel), .wb_dat_o(datO), .wb_ack_o(ack), .wfiExec(wfi), .wakeIrq(wake),
        .xtalOsc(xO), .hircOsc(hO), .lircOsc(lO), .xtalEnable(xE), .hircEnable(hE),
        .lircEnable(lE), .powerDown(pd), .sysClkTick(sysT), .extTickClk(extT),
        .systickCountTick(cntT), .periTick(periT), .divTick(divT));
    ccc_osc_model i_ccc_osc_model (.mclk(mclk), .xtalEnable(xE), .hircEnable(hE),
        .lircEnable(lE), .xtalOsc(xO), .hircOsc(hO), .lircOsc(lO));

    initial begin
        forever #20 mclk = ~mclk;
    end
    // pulse and source-edge counters; windows are taken as differences
    // counting waits for reset so unknown outputs never enter the sums
    always @(posedge mclk) begin
        if (reset_n) begin
            for (int i = 0; i < 9; i++) cnt[i] <= cnt[i] + periT[i];
            cnt[9] <= cnt[9] + sysT;
            cnt[10] <= cnt[10] + cntT;
            cnt[11] <= cnt[11] + divT;
            cnt[12] <= cnt[12] + (lO & ~lP);
            cnt[13] <= cnt[13] + (xO & ~xP);
            cnt[14] <= cnt[14] + (hO & ~hP);
            cnt[15] <= cnt[15] + extT;
        end
        {xP, hP, lP} <= {xO, hO, lO};
    end

    function automatic logic [31:0] near(input int a, input int b, input int t);
        return {31'h0, (a - b <= t) && (b - a <= t)};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // classic cycle: hold everything until ack is sampled, then release
    // no cycle count is assumed: only the watchdog ends a wait for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, v};
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        r = datO;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    task automatic meas(input int n);
        int s[16];
        repeat (40) @(posedge mclk);
        s = cnt;
        repeat (n) @(posedge mclk);
        foreach (d[i]) d[i] = cnt[i] - s[i];
    endtask
    // one-cycle request pulse, then one edge for the answer to land
    task automatic pulse(input logic w);
        @(posedge mclk);
        if (w) wake <= 1'b1;
        else wfi <= 1'b1;
        @(posedge mclk);
        {wake, wfi} <= 2'b00;
        @(posedge mclk);
    endtask
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // hang guard: the whole run needs well under 20000 cycles
    initial begin
        #800000;
        err_total++;
        final_report();
    end

    initial begin
        logic [31:0] v, e;
        int c;
        foreach (cnt[i]) cnt[i] = 0;
        void'($urandom(32'h75bd));
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        // reset values, status and an unmapped place
        chk({hE, lE, xE, pd}, 4'hC);
        rd(8'h00, 32'h10);
        rd(8'h04, 32'h07);
        rd(8'h08, 32'h3FFFF);
        rd(8'h0C, 32'h0);
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h4);
        rd(8'h18, 32'hA);
        rd(8'h1C, 32'h0);
        $display("test reset done");
        // system select codes, then four tick sources and the core clock
        wb(1'b1, 8'h00, 32'h14);
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? 0 : (k == 1) ? 3 : (k == 2) ? 7 : 5;
            wb(1'b1, 8'h04, v);
            meas(280);
            c = (k == 0) ? 13 : (k == 1) ? 12 : 14;
            chk(near(d[9], d[c], 2), 32'h1);
        end
        for (int k = 0; k < 5; k++) begin
            wb(1'b1, 8'h14, (k == 4) ? 32'h4 : 32'h0);
            // codes above three must also pick the bus clock
            wb(1'b1, 8'h04, (((k == 4) ? 2 : (k == 3) ? $urandom_range(7, 3) : k) << 3) | 7);
            meas(280);
            c = (k == 0) ? 13 : (k == 2) ? 12 : 14;
            chk(near(d[10], d[c], 2), 32'h1);
            c = (k == 0) ? 13 : (k % 2 == 0) ? 12 : 14;
            chk(near(d[15], d[c], 2), 32'h1);
        end
        $display("test muxes done");
        // engine sources per peripheral with random gates
        for (int k = 0; k < 6; k++) begin
            v = (k < 4) ? {9{k[1:0]}} : $urandom() & 32'h3FFFF;
            e = $urandom() & 32'h1FF;
            wb(1'b1, 8'h08, v);
            wb(1'b1, 8'h0C, e);
            rd(8'h0C, e);
            meas(200);
            for (int i = 0; i < 9; i++) begin
                c = v[2*i+:2];
                if (e[i] && OK_TAB[4*i+c]) chk(near(d[i], d[SRC_IDX[c]], 2), 32'h1);
                else chk(d[i], 32'h0);
            end
        end
        $display("test peripherals done");
        // divider ratios at both ends of the field and one random, then a random one with the divider disabled
        for (int k = 0; k < 4; k++) begin
            c = (k == 0) ? 0 : (k == 1) ? 15 : $urandom_range(14, 1);
            wb(1'b1, 8'h10, 32'hFFFFFF00 | c | ((k < 3) << 4) | (1 << 5));
            rd(8'h10, c | ((k < 3) << 4) | (1 << 5));
            meas(420);
            if (k < 3) chk(near(d[11], d[14] / (c + 1), 1), 32'h1);
            else chk(d[11], 32'h0);
        end
        $display("test divider done");
        // power-down: either condition alone, then both
        wb(1'b1, 8'h08, 32'h3FFF2);
        wb(1'b1, 8'h0C, 32'h1FF);
        wb(1'b1, 8'h00, 32'h1A);
        pulse(1'b0);
        chk(pd, 1'b0);
        wb(1'b1, 8'h00, 32'h1B);
        repeat (5) @(posedge mclk);
        chk(pd, 1'b0);
        pulse(1'b0);
        chk({pd, hE, xE, lE}, 4'hB);
        meas(200);
        chk(d[9], 32'h0);
        chk(d[1] + d[3], 32'h0);
        chk(near(d[0], d[12], 2), 32'h1);
        chk(pd, 1'b1);
        pulse(1'b1);
        chk({pd, hE}, 2'b01);
        wb(1'b1, 8'h00, 32'h19);
        pulse(1'b0);
        chk({pd, hE, xE}, 3'b100);
        pulse(1'b1);
        chk({pd, hE, xE}, 3'b011);
        $display("test power-down done");
        final_report();
    end
endmodule // ccc_clock_controller_tb_top
`default_nettype wire

// ===== sim/ccc_osc_model.sv
// oscillator model: three waveforms that run only while enabled
`timescale 1ns/100ps
`default_nettype none
module ccc_osc_model (
    input  wire logic mclk,
    input  wire logic xtalEnable,
    input  wire logic hircEnable,
    input  wire logic lircEnable,
    output logic      xtalOsc,
    output logic      hircOsc,
    output logic      lircOsc
);
    int xCnt;
    int hCnt;
    int lCnt;
    // start quiet so the first source tick comes from a real edge
    initial begin
        xtalOsc = 1'b0;
        hircOsc = 1'b0;
        lircOsc = 1'b0;
        xCnt = 0;
        hCnt = 0;
        lCnt = 0;
    end
    // half periods 3, 2 and 7 mclk cycles; a stopped source rests low
    // an enable not yet out of reset counts as off, so no unknown sticks in the counters
    always @(posedge mclk) begin
        xCnt <= (xtalEnable === 1'b1) ? (xCnt + 1) % 3 : 0;
        hCnt <= (hircEnable === 1'b1) ? (hCnt + 1) % 2 : 0;
        lCnt <= (lircEnable === 1'b1) ? (lCnt + 1) % 7 : 0;
        xtalOsc <= (xtalEnable === 1'b1) & (xCnt == 2 ? ~xtalOsc : xtalOsc);
        hircOsc <= (hircEnable === 1'b1) & (hCnt == 1 ? ~hircOsc : hircOsc);
        lircOsc <= (lircEnable === 1'b1) & (lCnt == 6 ? ~lircOsc : lircOsc);
    end
endmodule // ccc_osc_model
`default_nettype wire
